/* File: rtl/pcrnc_pkg.sv */
// Shared constants and types for the configuration and reset controller
package pcrnc_pkg;

  // Register addresses as seen on the serial port
  localparam logic [14:0] ADDR_SOFT_RESET_CTRL  = 15'h001C;
  localparam logic [14:0] ADDR_HARD_RESET_CTRL  = 15'h001E;
  localparam logic [14:0] ADDR_NVM_BANK         = 15'h00E3;
  localparam logic [14:0] ADDR_NVM_RELOAD       = 15'h00E4;
  localparam logic [14:0] ADDR_READY_STATUS     = 15'h00FE;
  localparam logic [14:0] ADDR_LOCK_STATUS      = 15'h0010;
  localparam logic [14:0] ADDR_SCRATCH_FIRST    = 15'h026B;
  localparam logic [14:0] ADDR_SCRATCH_LAST     = 15'h0272;
  localparam logic [14:0] ADDR_GUARD_C          = 15'h0540;
  localparam logic [14:0] ADDR_GUARD_A          = 15'h0B24;
  localparam logic [14:0] ADDR_GUARD_B          = 15'h0B25;

  // Field positions and codes
  localparam int          SOFT_RESET_BIT        = 0;
  localparam int          HARD_RESET_BIT        = 1;
  localparam int          RELOAD_BIT            = 0;
  localparam logic [7:0]  NVM_PROGRAM_CODE      = 8'hC7;
  localparam logic [7:0]  READY_CODE            = 8'h0F;
  localparam logic [7:0]  BUSY_CODE             = 8'h00;
  localparam logic [7:0]  NVM_MAX_WRITES        = 8'h02;
  localparam logic [7:0]  BANK_COUNT_RESET      = 8'h00;

  // Stored configuration bytes, addressed by index
  localparam int          CFG_BYTES             = 11;
  localparam logic [3:0]  CFG_GUARD_A           = 4'h0;
  localparam logic [3:0]  CFG_GUARD_B           = 4'h1;
  localparam logic [3:0]  CFG_GUARD_C           = 4'h2;
  localparam logic [3:0]  CFG_SCRATCH0          = 4'h3;

  // Serial frame: read flag, 15 address bits, 8 data bits
  localparam int          HDR_BITS              = 16;
  localparam int          FRAME_BITS            = 24;

  // Timing
  localparam int          CLK_PERIOD_NS         = 40;
  localparam int          INIT_TIME_NS          = 100000;
  localparam int          NVM_PROG_TIME_NS      = 10000000;
  localparam int          INIT_CYCLES_DEF       =
    (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          NVM_PROG_CYCLES_DEF   =
    (NVM_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    CS_INIT = 3'b001,
    CS_RUN  = 3'b010,
    CS_PROG = 3'b100
  } pcrnc_ctrl_state_t;

  typedef enum logic [3:0] {
    LM_FREERUN = 4'b0001,
    LM_ACQ     = 4'b0010,
    LM_LOCKED  = 4'b0100,
    LM_HOLD    = 4'b1000
  } pcrnc_loop_mode_t;

  typedef struct packed {
    logic        wr;
    logic [14:0] addr;
    logic [7:0]  data;
  } pcrnc_link_req_t;

endpackage : pcrnc_pkg

/* File: rtl/pcrnc_tog_sync.sv */
// Toggle synchroniser that turns a far-domain toggle into one pulse
`timescale 1ns/1ps
module pcrnc_tog_sync #(
  parameter int STAGES = 3
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_tog,
  output logic      o_event
);

  if (STAGES < 3) begin : g_bad_stages
    $error("pcrnc_tog_sync needs at least three stages");
  end

  typedef struct packed {
    logic [STAGES-1:0] sh;
    logic              seen;
    logic              pulse;
  } pcrnc_sync_state_t;

  pcrnc_sync_state_t s;
  pcrnc_sync_state_t next_s;

  // A change counts only once the last two stages agree
  always_comb begin
    next_s       = s;
    next_s.sh    = {s.sh[STAGES-2:0], i_tog};
    next_s.pulse = 1'b0;
    if ((s.sh[STAGES-1] == s.sh[STAGES-2]) && (s.sh[STAGES-1] != s.seen)) begin
      next_s.seen  = s.sh[STAGES-1];
      next_s.pulse = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_event = s.pulse;

endmodule : pcrnc_tog_sync

/* File: rtl/pcrnc_ctrl.sv */
// Loop mode, reset, memory load and program control with serial port
`timescale 1ns/1ps
// Operation
// - After initialization the loop is always in exactly one of four modes.
// - Power-up loads registers from memory; port unusable until that ends.
// - Output clocks stay disabled until initialization completes.
// - Reset pin or hard-reset bit reloads all from memory, resets port. The pin reset also clears the memory, so it loads zeros.
// - Soft-reset bit applies pending register changes without memory load.
// - Output divider writes leave the loop undisturbed.
// - Memory takes only two writes; new contents replace old ones.
// - Writing 0xC7 to program register stores current registers.
// - Reading the program address returns the count of bank writes.
// - Ready register reads 0x0F only while the port accepts commands.
// - After initialization the loop enters free-run automatically.
// - Any valid input starts lock acquisition automatically.
// - With fast lock on, acquisition uses fast bandwidth, then normal.
// - Lock state shows on a loss-of-lock pin and a status bit.
// - Selected input lost with none other valid enters holdover; code does so from locked only, acquisition falls back to free-run.
module pcrnc_ctrl
  import pcrnc_pkg::*;
#(
  parameter int NUM_INPUTS      = 2,
  parameter int INIT_CYCLES     = INIT_CYCLES_DEF,
  parameter int NVM_PROG_CYCLES = NVM_PROG_CYCLES_DEF
) (
  input  wire logic                        i_mclk,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_sclk,
  input  wire logic                        i_cs_n,
  input  wire logic                        i_mosi,
  output logic                             o_miso,
  output logic                             o_miso_oe,
  input  wire logic [NUM_INPUTS-1:0]       i_clk_valid,
  input  wire logic                        i_acq_done,
  input  wire logic                        i_fastlock_en,
  output pcrnc_loop_mode_t                 o_loop_mode,
  output logic                             o_lock_lost,
  output logic                             o_outputs_en,
  output logic                             o_fastlock_bw,
  output logic [CFG_BYTES-1:0][7:0]        o_applied_cfg,
  output logic                             o_cfg_update
);

  if (NUM_INPUTS < 1 || INIT_CYCLES < 1 || NVM_PROG_CYCLES < 1) begin : g_bad
    $error("pcrnc_ctrl parameters must all be at least one");
  end

  localparam int CNT_MAX =
    (INIT_CYCLES > NVM_PROG_CYCLES) ? INIT_CYCLES : NVM_PROG_CYCLES;
  localparam int CNT_W = $clog2(CNT_MAX + 1);
  localparam logic [CNT_W-1:0] INIT_LOAD = CNT_W'(INIT_CYCLES);
  localparam logic [CNT_W-1:0] PROG_LOAD = CNT_W'(NVM_PROG_CYCLES);

  // Main clock domain state
  typedef struct packed {
    pcrnc_ctrl_state_t          st;
    logic [CNT_W-1:0]           cnt;
    pcrnc_loop_mode_t           mode;
    logic [CFG_BYTES-1:0][7:0]  pend;
    logic [CFG_BYTES-1:0][7:0]  appl;
    logic [CFG_BYTES-1:0][7:0]  nvm;
    logic [7:0]                 bank_cnt;
    logic [7:0]                 rd_data;
    logic                       resp_tog;
    logic                       link_hold;
    logic                       out_en;
    logic                       lock_lost;
    logic                       fast_bw;
    logic                       cfg_update;
  } pcrnc_mstate_t;

  // Serial clock domain state
  typedef struct packed {
    logic [4:0]                 bitcnt;
    logic [22:0]                shift;
    pcrnc_link_req_t            req;
    logic                       req_tog;
    logic [7:0]                 rd_hold;
    logic [7:0]                 miso_sh;
    logic                       miso;
    logic                       miso_oe;
  } pcrnc_lstate_t;

  // Memory content lives in flops, so the pin reset also clears it
  localparam pcrnc_mstate_t M_RESET = '{
    st:         CS_INIT,
    cnt:        INIT_LOAD,
    mode:       LM_FREERUN,
    pend:       '0,
    appl:       '0,
    nvm:        '0,
    bank_cnt:   BANK_COUNT_RESET,
    rd_data:    8'h00,
    resp_tog:   1'b0,
    link_hold:  1'b1,
    out_en:     1'b0,
    lock_lost:  1'b1,
    fast_bw:    1'b0,
    cfg_update: 1'b0
  };

  pcrnc_mstate_t   m;
  pcrnc_mstate_t   next_m;
  pcrnc_lstate_t   l;
  pcrnc_lstate_t   next_l;
  pcrnc_link_req_t req;
  logic            link_rst;
  logic            req_ev;
  logic            resp_ev;
  logic            any_valid;
  logic            ready;
  logic            cfg_hit;
  logic [3:0]      cfg_idx;
  logic [7:0]      rd_val;
  logic [15:0]     hdr;
  logic [23:0]     frame;

  // Port logic is held in reset during the whole hard-reset load
  assign link_rst = i_sys_rst | m.link_hold;

  pcrnc_tog_sync #(
    .STAGES (3)
  ) u_req_sync (
    .i_clk   (i_mclk),
    .i_rst   (link_rst),
    .i_tog   (l.req_tog),
    .o_event (req_ev)
  );

  pcrnc_tog_sync #(
    .STAGES (3)
  ) u_resp_sync (
    .i_clk   (i_sclk),
    .i_rst   (link_rst),
    .i_tog   (m.resp_tog),
    .o_event (resp_ev)
  );

  always_comb begin
    next_m            = m;
    next_m.cfg_update = 1'b0;
    req               = l.req;
    any_valid         = |i_clk_valid;
    ready             = (m.st == CS_RUN);
    cfg_hit           = 1'b0;
    cfg_idx           = 4'h0;
    rd_val            = 8'h00;

    // Map a port address onto a stored configuration byte
    if (req.addr == ADDR_GUARD_A) begin
      cfg_hit = 1'b1;
      cfg_idx = CFG_GUARD_A;
    end else if (req.addr == ADDR_GUARD_B) begin
      cfg_hit = 1'b1;
      cfg_idx = CFG_GUARD_B;
    end else if (req.addr == ADDR_GUARD_C) begin
      cfg_hit = 1'b1;
      cfg_idx = CFG_GUARD_C;
    end else if (req.addr >= ADDR_SCRATCH_FIRST &&
                 req.addr <= ADDR_SCRATCH_LAST) begin
      cfg_hit = 1'b1;
      cfg_idx = 4'(req.addr - ADDR_SCRATCH_FIRST) + CFG_SCRATCH0;
    end

    // Load, program and run sequencing
    case (m.st)
      CS_INIT: begin
        if (m.cnt == '0) begin
          next_m.pend       = m.nvm;
          next_m.appl       = m.nvm;
          next_m.st         = CS_RUN;
          next_m.out_en     = 1'b1;
          next_m.link_hold  = 1'b0;
          next_m.cfg_update = 1'b1;
        end else begin
          next_m.cnt = m.cnt - 1'b1;
        end
      end
      CS_PROG: begin
        if (m.cnt == '0) begin
          next_m.st = CS_RUN;
        end else begin
          next_m.cnt = m.cnt - 1'b1;
        end
      end
      CS_RUN: begin
        next_m.cnt = '0;
      end
      default: begin
        next_m.st  = CS_INIT;
        next_m.cnt = INIT_LOAD;
      end
    endcase

    // Loop mode sequencing, frozen in free-run while loading
    if (m.st == CS_INIT) begin
      next_m.mode = LM_FREERUN;
    end else begin
      case (m.mode)
        LM_FREERUN: begin
          if (any_valid) begin
            next_m.mode = LM_ACQ;
          end
        end
        LM_ACQ: begin
          if (!any_valid) begin
            next_m.mode = LM_FREERUN;
          end else if (i_acq_done) begin
            next_m.mode = LM_LOCKED;
          end
        end
        LM_LOCKED: begin
          if (!any_valid) begin
            next_m.mode = LM_HOLD;
          end
        end
        LM_HOLD: begin
          if (any_valid) begin
            next_m.mode = LM_ACQ;
          end
        end
        default: begin
          next_m.mode = LM_FREERUN;
        end
      endcase
    end

    // Read data; busy periods answer only the ready register
    if (req.addr == ADDR_READY_STATUS) begin
      rd_val = ready ? READY_CODE : BUSY_CODE;
    end else if (!ready) begin
      rd_val = 8'h00;
    end else if (req.addr == ADDR_NVM_BANK) begin
      rd_val = m.bank_cnt;
    end else if (req.addr == ADDR_LOCK_STATUS) begin
      rd_val = {3'b000, m.lock_lost, m.mode};
    end else if (cfg_hit) begin
      rd_val = m.pend[cfg_idx];
    end

    if (req_ev) begin
      if (!req.wr) begin
        next_m.rd_data  = rd_val;
        next_m.resp_tog = ~m.resp_tog;
      end else if (ready) begin
        // Control bits are never stored, so each write acts once
        case (req.addr)
          ADDR_SOFT_RESET_CTRL: begin
            if (req.data[SOFT_RESET_BIT]) begin
              next_m.appl       = m.pend;
              next_m.cfg_update = 1'b1;
              next_m.mode       = LM_FREERUN;
            end
          end
          ADDR_HARD_RESET_CTRL: begin
            if (req.data[HARD_RESET_BIT]) begin
              next_m.st        = CS_INIT;
              next_m.cnt       = INIT_LOAD;
              next_m.link_hold = 1'b1;
              next_m.out_en    = 1'b0;
              next_m.mode      = LM_FREERUN;
              next_m.resp_tog  = 1'b0;
            end
          end
          ADDR_NVM_BANK: begin
            if (req.data == NVM_PROGRAM_CODE &&
                m.bank_cnt < NVM_MAX_WRITES) begin
              next_m.nvm      = m.pend;
              next_m.bank_cnt = m.bank_cnt + 8'h01;
              next_m.st       = CS_PROG;
              next_m.cnt      = PROG_LOAD;
            end
          end
          ADDR_NVM_RELOAD: begin
            if (req.data[RELOAD_BIT]) begin
              next_m.st  = CS_INIT;
              next_m.cnt = INIT_LOAD;
            end
          end
          default: begin
            // Plain writes only reach pending bytes, never the loop
            if (cfg_hit) begin
              next_m.pend[cfg_idx] = req.data;
            end
          end
        endcase
      end
    end

    next_m.lock_lost = (next_m.mode != LM_LOCKED);
    next_m.fast_bw   = i_fastlock_en && (next_m.mode == LM_ACQ);
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      m <= M_RESET;
    end else begin
      m <= next_m;
    end
  end

  // Read answers come one frame late because the port clock is too
  // fast for the answer to cross within the same frame
  always_comb begin
    next_l = l;
    hdr    = {l.shift[14:0], i_mosi};
    frame  = {l.shift, i_mosi};
    if (resp_ev) begin
      next_l.rd_hold = m.rd_data;
    end
    if (!i_cs_n) begin
      next_l.shift = {l.shift[21:0], i_mosi};
      if (l.bitcnt == 5'(HDR_BITS - 1)) begin
        if (hdr[15]) begin
          next_l.req     = '{wr: 1'b0, addr: hdr[14:0], data: 8'h00};
          next_l.req_tog = ~l.req_tog;
          next_l.miso_oe = 1'b1;
          next_l.miso    = l.rd_hold[7];
          next_l.miso_sh = {l.rd_hold[6:0], 1'b0};
        end
        next_l.bitcnt = l.bitcnt + 5'd1;
      end else if (l.bitcnt == 5'(FRAME_BITS - 1)) begin
        if (!frame[23]) begin
          next_l.req     = '{wr: 1'b1, addr: frame[22:8], data: frame[7:0]};
          next_l.req_tog = ~l.req_tog;
        end
        next_l.miso_oe = 1'b0;
        next_l.miso    = 1'b0;
        next_l.bitcnt  = 5'd0;
      end else begin
        if (l.bitcnt >= 5'(HDR_BITS)) begin
          next_l.miso    = l.miso_sh[7];
          next_l.miso_sh = {l.miso_sh[6:0], 1'b0};
        end
        next_l.bitcnt = l.bitcnt + 5'd1;
      end
    end
  end

  always_ff @(posedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  assign o_miso        = l.miso;
  assign o_miso_oe     = l.miso_oe;
  assign o_loop_mode   = m.mode;
  assign o_lock_lost   = m.lock_lost;
  assign o_outputs_en  = m.out_en;
  assign o_fastlock_bw = m.fast_bw;
  assign o_applied_cfg = m.appl;
  assign o_cfg_update  = m.cfg_update;

endmodule : pcrnc_ctrl

/* File: bench/pcrnc_ctrl_chk.sv */
// Port assertions for the configuration and reset controller
`timescale 1ns/1ps
module pcrnc_ctrl_chk
  import pcrnc_pkg::*;
#(
  parameter int NUM_INPUTS  = 2,
  parameter int INIT_CYCLES = 8
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_sys_rst,
  input  wire logic [NUM_INPUTS-1:0] i_clk_valid,
  input  wire logic                  i_acq_done,
  input  wire logic                  i_fastlock_en,
  input  pcrnc_loop_mode_t           o_loop_mode,
  input  wire logic                  o_lock_lost,
  input  wire logic                  o_outputs_en,
  input  wire logic                  o_fastlock_bw,
  input  wire logic                  o_cfg_update
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // Cycles since reset release, saturating
  logic [15:0] cnt;
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst)
      cnt <= '0;
    else if (cnt < 16'(INIT_CYCLES + 8))
      cnt <= cnt + 16'h0001;
  end
  property p_one_mode; $onehot(o_loop_mode); endproperty
  a_one_mode: assert property (p_one_mode)
    else $error("loop mode not one-hot");
  property p_lock_flag; o_lock_lost == (o_loop_mode != LM_LOCKED);
  endproperty
  a_lock_flag: assert property (p_lock_flag)
    else $error("lock lost flag disagrees with mode");
  property p_fast_bw;
    o_fastlock_bw == ($past(i_fastlock_en) && o_loop_mode == LM_ACQ);
  endproperty
  a_fast_bw: assert property (p_fast_bw)
    else $error("fast bandwidth select wrong");
  property p_start_acq; o_outputs_en && o_loop_mode == LM_FREERUN &&
    |i_clk_valid |=> o_loop_mode == LM_ACQ; endproperty
  a_start_acq: assert property (p_start_acq)
    else $error("valid input did not start acquisition");
  property p_to_lock; o_loop_mode == LM_ACQ && i_acq_done &&
    |i_clk_valid |=> o_loop_mode == LM_LOCKED; endproperty
  a_to_lock: assert property (p_to_lock)
    else $error("acquisition done did not lock");
  property p_to_hold; o_loop_mode == LM_LOCKED && !(|i_clk_valid)
    |=> o_loop_mode == LM_HOLD; endproperty
  a_to_hold: assert property (p_to_hold)
    else $error("input loss did not enter holdover");
  property p_init_off; cnt < 16'(INIT_CYCLES) |-> !o_outputs_en;
  endproperty
  a_init_off: assert property (p_init_off)
    else $error("outputs enabled during initialization");
  property p_init_on; cnt == 16'(INIT_CYCLES + 4) |-> o_outputs_en;
  endproperty
  a_init_on: assert property (p_init_on)
    else $error("initialization did not finish");
  property p_update; $rose(o_outputs_en) |-> o_cfg_update ##1 !o_cfg_update;
  endproperty
  a_update: assert property (p_update)
    else $error("config update not a single pulse");
  property p_freerun; !o_outputs_en |-> o_loop_mode == LM_FREERUN;
  endproperty
  a_freerun: assert property (p_freerun)
    else $error("mode not free-run while outputs held off");
endmodule : pcrnc_ctrl_chk
bind pcrnc_ctrl pcrnc_ctrl_chk #(
  .NUM_INPUTS(NUM_INPUTS), .INIT_CYCLES(INIT_CYCLES)
) chk_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
  .i_clk_valid(i_clk_valid), .i_acq_done(i_acq_done),
  .i_fastlock_en(i_fastlock_en), .o_loop_mode(o_loop_mode),
  .o_lock_lost(o_lock_lost), .o_outputs_en(o_outputs_en),
  .o_fastlock_bw(o_fastlock_bw), .o_cfg_update(o_cfg_update));

/* File: bench/pcrnc_host.sv */
// Host model driving the serial configuration port
`timescale 1ns/1ps
module pcrnc_host (
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_mosi,
  input  wire logic i_miso,
  input  wire logic i_miso_oe
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // Clock only runs inside a frame; data sampled on falling edge
  task automatic xfer(input logic rd, input logic [14:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [23:0] f;
    f = {rd, a, d};
    q = 8'h00;
    #7 o_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      o_mosi = f[i];
      #62.5 o_sclk = 1'b1;
      #62.5 o_sclk = 1'b0;
      if (i_miso_oe)
        q = {q[6:0], i_miso};
    end
    #62.5 o_cs_n = 1'b1;
    // Released line must not keep showing the last bit
    o_mosi = ~o_mosi;
  endtask : xfer
endmodule : pcrnc_host

/* File: bench/test_pll_config_reset_nvm_control.sv */
// Self-checking bench for the configuration and reset controller
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[FAIL] %s expected %h seen %h", nm, e, g); \
  end end
module test_pll_config_reset_nvm_control
  import pcrnc_pkg::*;
;
  logic i_mclk, i_sys_rst, i_sclk, i_cs_n, i_mosi, o_miso, o_miso_oe;
  logic [1:0]                 i_clk_valid;
  logic                       i_acq_done, i_fastlock_en;
  pcrnc_loop_mode_t           o_loop_mode, exp;
  logic                       o_lock_lost, o_outputs_en, o_fastlock_bw;
  logic [CFG_BYTES-1:0][7:0]  o_applied_cfg;
  logic                       o_cfg_update;
  int                         n_mismatch = 0;
  int                         num_checks = 0;
  always #20 i_mclk = ~i_mclk;
  // Short counts keep the run brief; programming still spans a poll
  pcrnc_ctrl #(.NUM_INPUTS(2), .INIT_CYCLES(100), .NVM_PROG_CYCLES(400))
  pcrnc_ctrl_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_mosi(i_mosi), .o_miso(o_miso),
    .o_miso_oe(o_miso_oe), .i_clk_valid(i_clk_valid),
    .i_acq_done(i_acq_done), .i_fastlock_en(i_fastlock_en),
    .o_loop_mode(o_loop_mode), .o_lock_lost(o_lock_lost),
    .o_outputs_en(o_outputs_en), .o_fastlock_bw(o_fastlock_bw),
    .o_applied_cfg(o_applied_cfg), .o_cfg_update(o_cfg_update));
  pcrnc_host pcrnc_host_inst (.o_sclk(i_sclk), .o_cs_n(i_cs_n),
    .o_mosi(i_mosi), .i_miso(o_miso), .i_miso_oe(o_miso_oe));
  function automatic pcrnc_loop_mode_t nxt(pcrnc_loop_mode_t m,
                                           logic [1:0] v, logic d);
    if (m == LM_ACQ)
      return (v == 2'b00) ? LM_FREERUN : (d ? LM_LOCKED : LM_ACQ);
    if (m == LM_LOCKED)
      return (v == 2'b00) ? LM_HOLD : LM_LOCKED;
    return (v != 2'b00) ? LM_ACQ : m;
  endfunction : nxt
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    pcrnc_host_inst.xfer(1'b0, a, d, q);
    repeat (12) @(negedge i_mclk);
  endtask : wr
  // Reads are pipelined: the second frame returns the first one's data
  task automatic rd(input logic [14:0] a, output logic [7:0] q);
    pcrnc_host_inst.xfer(1'b1, a, 8'h00, q);
    pcrnc_host_inst.xfer(1'b1, a, 8'h00, q);
    @(negedge i_mclk);
  endtask : rd
  task automatic poll();
    logic [7:0] q;
    int n;
    n = 0;
    q = 8'h00;
    while (q !== READY_CODE && n < 40) begin
      rd(ADDR_READY_STATUS, q);
      n++;
    end
    `CHECK("ready", READY_CODE, q);
  endtask : poll
  task automatic wait_en();
    int n;
    n = 0;
    while (o_outputs_en !== 1'b1 && n < 400) begin
      @(negedge i_mclk);
      n++;
    end
    `CHECK("outputs_en", 1'b1, o_outputs_en);
  endtask : wait_en
  initial begin
    #(40 * 80000);
    n_mismatch++;
    finish_test();
  end
  initial begin
    logic [7:0] q;
    i_mclk = 1'b0;
    i_sys_rst = 1'b1;
    i_clk_valid = 2'b00;
    i_acq_done = 1'b0;
    i_fastlock_en = 1'b0;
    void'($urandom(32'h7f2f));
    repeat (16) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    wait_en();
    rd(ADDR_READY_STATUS, q);
    `CHECK("ready", READY_CODE, q);
    rd(ADDR_NVM_BANK, q);
    `CHECK("bank_count", BANK_COUNT_RESET, q);
    exp = LM_FREERUN;
    repeat (600) begin
      @(negedge i_mclk);
      `CHECK("loop_mode", exp, o_loop_mode);
      `CHECK("lock_lost", exp != LM_LOCKED, o_lock_lost);
      `CHECK("fast_bw", i_fastlock_en && exp == LM_ACQ, o_fastlock_bw);
      if ($urandom % 8 == 0)
        i_clk_valid = 2'($urandom);
      i_acq_done = (i_clk_valid != 2'b00) && ($urandom % 4 == 0);
      i_fastlock_en = 1'($urandom);
      @(posedge i_mclk);
      exp = nxt(exp, i_clk_valid, i_acq_done);
    end
    @(negedge i_mclk);
    i_clk_valid = 2'b00;
    i_acq_done = 1'b0;
    // Loop changes above the drift limit sit inside the guard writes
    wr(ADDR_GUARD_A, 8'hC0);
    wr(ADDR_GUARD_B, 8'h00);
    wr(ADDR_GUARD_C, 8'h01);
    wr(ADDR_SCRATCH_FIRST, 8'h5A);
    `CHECK("pending", 8'h00, o_applied_cfg[CFG_GUARD_A]);
    // Settling wait left out: the model has no analog loop
    wr(ADDR_SOFT_RESET_CTRL, 8'h01);
    `CHECK("guard_a", 8'hC0, o_applied_cfg[CFG_GUARD_A]);
    `CHECK("guard_c", 8'h01, o_applied_cfg[CFG_GUARD_C]);
    `CHECK("scratch", 8'h5A, o_applied_cfg[CFG_SCRATCH0]);
    wr(ADDR_GUARD_C, 8'h00);
    wr(ADDR_GUARD_A, 8'hC3);
    wr(ADDR_GUARD_B, 8'h02);
    `CHECK("unapplied", 8'hC0, o_applied_cfg[CFG_GUARD_A]);
    wr(ADDR_NVM_BANK, NVM_PROGRAM_CODE);
    rd(ADDR_READY_STATUS, q);
    `CHECK("busy", BUSY_CODE, q);
    poll();
    rd(ADDR_NVM_BANK, q);
    `CHECK("bank_count", 8'h01, q);
    wr(ADDR_NVM_RELOAD, 8'h01);
    poll();
    `CHECK("reloaded", 8'hC3, o_applied_cfg[CFG_GUARD_A]);
    wr(ADDR_GUARD_A, 8'h3C);
    wr(ADDR_NVM_BANK, NVM_PROGRAM_CODE);
    poll();
    // A refused third store must leave the second bank in memory
    wr(ADDR_GUARD_A, 8'hAA);
    wr(ADDR_NVM_BANK, NVM_PROGRAM_CODE);
    poll();
    rd(ADDR_NVM_BANK, q);
    `CHECK("bank_count", NVM_MAX_WRITES, q);
    wr(ADDR_HARD_RESET_CTRL, 8'h02);
    `CHECK("outputs_off", 1'b0, o_outputs_en);
    wait_en();
    `CHECK("nvm_load", 8'h3C, o_applied_cfg[CFG_GUARD_A]);
    rd(ADDR_HARD_RESET_CTRL, q);
    `CHECK("self_clear", 8'h00, q);
    rd(ADDR_NVM_BANK, q);
    `CHECK("bank_kept", NVM_MAX_WRITES, q);
    rd(15'h0123, q);
    `CHECK("unmapped", 8'h00, q);
    finish_test();
  end
endmodule : test_pll_config_reset_nvm_control
